/* logic/dsc_engine.sv */
// Debug command engine, device end of the serial debug link
// What this block does
// - Bit 3 selects address/data, bits 2..0 number
// - Address two words; data one or two
// - Low address bits forced to alignment
// - Multi-word values sent high word first
// - Each 17-bit transfer answers earlier commands
// - Opcode transfer returns prior result or status
// - After opcode: not-ready, or illegal if unknown
// - Third transfer not-ready; read starts after it
// - Transfers during memory access get not-ready
// - Accept next transfer 32 clocks later
// - Read results in next one or two transfers (two for long)
// - Byte read data in low eight bits
// - Bus error returns status set, 0x0001
// - Status clear on success, set otherwise
// - Unknown encodings act as no-op, illegal
// - Register read: 32 bits, error if running
// - Register write: 32 bits, 0xFFFF or error
// - Read opcode 0x19 plus size; attributes give space
// - Byte write low-justified; 0xFFFF or 0x0001
// - Dump only after no-op, read, dump
// - Dump reads saved address, then advances it
// - Fill only after write, no-op, fill
// - Not-ready 0x0000; illegal 0xFFFF, status set
// - Size 00 byte, 01 word, 10 long
//
// Chosen here: the register addresses and the plain strobed port.
`default_nettype none
module dsc_engine
(
    input  wire logic                sys_clk_in,
    input  wire logic                rst_n_in,
    input  wire logic                clk_en_in,
    dsc_link_if.dev                  link,
    input  wire logic                cpu_halted_in,
    input  wire logic [4:0]          attr_tt_tm_in,
    output logic                     mem_req_out,
    output logic                     mem_we_out,
    output logic [31:0]              mem_addr_out,
    output logic [1:0]               mem_size_out,
    output logic [31:0]              mem_wdata_out,
    output logic [4:0]               mem_attr_out,
    input  wire logic                mem_done_in,
    input  wire logic                mem_err_in,
    input  wire logic [31:0]         mem_rdata_in,
    output logic                     reg_we_out,
    output logic [3:0]               reg_sel_out,
    output logic [31:0]              reg_wdata_out,
    input  wire logic [31:0]         reg_rdata_in
);
    import dsc_pkg::*;

    typedef enum logic [4:0]
    {
        ST_OPC  = 5'h01,
        ST_EXT  = 5'h02,
        ST_MEM  = 5'h04,
        ST_RES  = 5'h08,
        ST_GAP  = 5'h10
    } dsc_state_t;

    // Align address to operand size
    function automatic logic [31:0] align_addr(input logic [31:0] a, input logic [1:0] sz);
        logic [31:0] r;
        r = a;
        if (sz == SZ_WORD)
            r[0] = 1'b0;
        else if (sz == SZ_LONG)
            r[1:0] = 2'h0;
        return r;
    endfunction

    // Increment for operand size
    function automatic logic [31:0] size_step(input logic [1:0] sz);
        logic [31:0] r;
        r = 32'h1;
        if (sz == SZ_WORD)
            r = 32'h2;
        else if (sz == SZ_LONG)
            r = 32'h4;
        return r;
    endfunction

    // Synchronisers
    logic [1:0]  sclk_sync_reg;
    logic [1:0]  sdi_sync_reg;
    logic        sclk_prev_reg;
    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            sclk_sync_reg <= 2'h0;
            sdi_sync_reg  <= 2'h0;
            sclk_prev_reg <= 1'b0;
        end
        else if (clk_en_in)
        begin
            sclk_sync_reg <= {sclk_sync_reg[0], link.sclk};
            sdi_sync_reg  <= {sdi_sync_reg[0], link.sdi};
            sclk_prev_reg <= sclk_sync_reg[1];
        end
    end
    logic sclk_rise;
    assign sclk_rise = clk_en_in && sclk_sync_reg[1] && !sclk_prev_reg;

    // Shifter: 17 bits in, 17 bits out, MSB first
    logic [16:0] rx_reg;
    logic [16:0] tx_reg;
    logic [4:0]  bit_cnt_reg;
    logic        frame_done;
    logic [16:0] resp;
    logic        sdo_reg;
    assign frame_done = sclk_rise && (bit_cnt_reg == 5'(FRAME_BITS - 1));
    logic [16:0] rx_full;
    assign rx_full = {rx_reg[15:0], sdi_sync_reg[1]};
    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            rx_reg      <= 17'h0;
            bit_cnt_reg <= 5'h0;
            sdo_reg     <= 1'b0;
            tx_reg      <= {RSP_OK, 1'b0};
        end
        else if (sclk_rise)
        begin
            rx_reg <= rx_full;
            if (frame_done)
            begin
                bit_cnt_reg <= 5'h0;
                tx_reg      <= {resp[15:0], 1'b0};
                sdo_reg     <= resp[16];
            end
            else
            begin
                bit_cnt_reg <= bit_cnt_reg + 5'h1;
                sdo_reg     <= tx_reg[16];
                tx_reg      <= {tx_reg[15:0], 1'b0};
            end
        end
    end
    assign link.sdo = sdo_reg;

    // Command engine
    dsc_state_t  state_reg;
    logic [15:0] cmd_reg;
    logic [15:0] prev_cmd_reg;
    logic [2:0]  ext_left_reg;
    logic [2:0]  res_left_reg;
    logic [31:0] addr_reg;
    logic [31:0] data_reg;
    logic [31:0] result_reg;
    logic [16:0] pend_reg;
    logic        err_reg;
    logic [5:0]  gap_reg;
    logic [1:0]  sz;
    logic [7:0]  op;
    logic        op_ok;
    logic        is_mem;
    logic        is_wr;
    assign sz = rx_full[SZ_HI:SZ_LO];
    assign op = rx_full[15:8];

    always_comb
    begin
        op_ok  = 1'b0;
        is_mem = 1'b0;
        is_wr  = 1'b0;
        if ((op == OP_RREG || op == OP_WREG) && rx_full[7:4] == REG_NIB)
            op_ok = 1'b1;
        else if (rx_full[5:0] == 6'h0 && sz != 2'h3)
        begin
            if (op == OP_READ || op == OP_WRITE)
                op_ok = 1'b1;
            // Dump legal after no-op, read, dump
            else if (op == OP_DUMP)
                op_ok = prev_cmd_reg == OP_NOP || prev_cmd_reg[15:8] == OP_READ
                        || prev_cmd_reg[15:8] == OP_DUMP;
            // Fill legal after write, no-op, fill
            else if (op == OP_FILL)
                op_ok = prev_cmd_reg == OP_NOP || prev_cmd_reg[15:8] == OP_WRITE
                        || prev_cmd_reg[15:8] == OP_FILL;
        end
        is_mem = op == OP_READ || op == OP_WRITE || op == OP_DUMP || op == OP_FILL;
        is_wr  = op == OP_WRITE || op == OP_FILL || op == OP_WREG;
    end

    // Response chosen at frame end for the next frame
    always_comb
    begin
        resp = pend_reg;
        if (state_reg == ST_MEM || state_reg == ST_GAP)
            resp = {1'b1, RSP_NOT_READY};
        else if (state_reg == ST_OPC && rx_full[15:0] != OP_NOP)
        begin
            if (!op_ok)
                resp = {1'b1, RSP_ILLEGAL};
            else
                resp = {1'b1, RSP_NOT_READY};
        end
        else if (state_reg == ST_EXT)
            resp = {1'b1, RSP_NOT_READY};
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            state_reg    <= ST_OPC;
            cmd_reg      <= OP_NOP;
            prev_cmd_reg <= 16'h0001;
            ext_left_reg <= 3'h0;
            res_left_reg <= 3'h0;
            addr_reg     <= 32'h0;
            data_reg     <= 32'h0;
            result_reg   <= 32'h0;
            pend_reg     <= {1'b0, RSP_OK};
            err_reg      <= 1'b0;
            gap_reg      <= 6'h0;
            mem_req_out  <= 1'b0;
            mem_we_out   <= 1'b0;
            mem_addr_out <= 32'h0;
            mem_size_out <= SZ_BYTE;
            mem_wdata_out<= 32'h0;
            mem_attr_out <= 5'h0;
            reg_we_out   <= 1'b0;
            reg_sel_out  <= 4'h0;
            reg_wdata_out<= 32'h0;
        end
        else if (clk_en_in)
        begin
            reg_we_out <= 1'b0;
            unique case (state_reg)
                ST_OPC:
                    if (frame_done)
                    begin
                        pend_reg <= {1'b0, RSP_OK};
                        if (rx_full[15:0] == OP_NOP)
                            prev_cmd_reg <= OP_NOP;
                        else if (!op_ok)
                            prev_cmd_reg <= 16'h0001;
                        else
                        begin
                            cmd_reg <= rx_full[15:0];
                            reg_sel_out <= rx_full[AD_BIT:0];
                            mem_size_out <= sz;
                            if (op == OP_RREG)
                                ext_left_reg <= 3'h0;
                            else if (op == OP_WREG)
                                ext_left_reg <= 3'h2;
                            else if (op == OP_READ)
                                ext_left_reg <= 3'h2;
                            else if (op == OP_WRITE)
                                ext_left_reg <= (sz == SZ_LONG) ? 3'h4 : 3'h3;
                            else if (op == OP_FILL)
                                ext_left_reg <= (sz == SZ_LONG) ? 3'h2 : 3'h1;
                            else
                                ext_left_reg <= 3'h0;
                            if (op == OP_RREG || op == OP_DUMP)
                                state_reg <= is_mem ? ST_MEM : ST_GAP;
                            else
                                state_reg <= ST_EXT;
                            if (op == OP_DUMP)
                            begin
                                mem_addr_out <= align_addr(addr_reg, sz);
                                mem_attr_out <= attr_tt_tm_in;
                                mem_we_out   <= 1'b0;
                                mem_req_out  <= 1'b1;
                            end
                            gap_reg <= 6'h0;
                        end
                    end
                ST_EXT:
                    if (frame_done)
                    begin
                        ext_left_reg <= ext_left_reg - 3'h1;
                        if (cmd_reg[15:8] == OP_READ || (cmd_reg[15:8] == OP_WRITE
                            && ext_left_reg > ((mem_size_out == SZ_LONG) ? 3'h2 : 3'h1)))
                            addr_reg <= {addr_reg[15:0], rx_full[15:0]};
                        else
                            data_reg <= {data_reg[15:0], rx_full[15:0]};
                        // Access starts after the last word
                        if (ext_left_reg == 3'h1)
                            state_reg <= (cmd_reg[15:8] == OP_WREG) ? ST_GAP : ST_MEM;
                        gap_reg <= 6'h0;
                    end
                    else if (mem_req_out == 1'b0 && ext_left_reg == 3'h0)
                        state_reg <= ST_OPC;
                ST_MEM:
                begin
                    mem_addr_out  <= align_addr(addr_reg, mem_size_out);
                    mem_attr_out  <= attr_tt_tm_in;
                    mem_we_out    <= is_wr_cmd(cmd_reg[15:8]);
                    // Byte data taken from low byte
                    mem_wdata_out <= data_reg;
                    // Request rises with address and data
                    mem_req_out   <= 1'b1;
                    if (mem_req_out && mem_done_in)
                    begin
                        mem_req_out <= 1'b0;
                        addr_reg <= align_addr(addr_reg, mem_size_out)
                                    + size_step(mem_size_out);
                        err_reg <= mem_err_in;
                        result_reg <= (mem_size_out == SZ_BYTE) ? {24'h0, mem_rdata_in[7:0]}
                                      : mem_rdata_in;
                        state_reg <= ST_RES;
                    end
                end
                ST_GAP:
                begin
                    gap_reg <= gap_reg + 6'h1;
                    if (gap_reg == 6'(GAP_CLKS - 2))
                    begin
                        err_reg <= !cpu_halted_in;
                        result_reg <= reg_rdata_in;
                        if (cmd_reg[15:8] == OP_WREG && cpu_halted_in)
                        begin
                            reg_we_out    <= 1'b1;
                            reg_wdata_out <= data_reg;
                        end
                        state_reg <= ST_RES;
                    end
                end
                ST_RES:
                begin
                    if (err_reg)
                        pend_reg <= {1'b1, RSP_BUS_ERR};
                    else if (cmd_reg[15:8] == OP_WRITE || cmd_reg[15:8] == OP_FILL
                             || cmd_reg[15:8] == OP_WREG)
                        pend_reg <= {1'b0, RSP_OK};
                    else if (mem_size_out == SZ_LONG || cmd_reg[15:8] == OP_RREG)
                        pend_reg <= {1'b0, result_reg[31:16]};
                    else
                        pend_reg <= {1'b0, result_reg[15:0]};
                    res_left_reg <= (!err_reg && (mem_size_out == SZ_LONG
                                     || cmd_reg[15:8] == OP_RREG) && !is_wr_cmd(cmd_reg[15:8])
                                     && cmd_reg[15:8] != OP_WREG)
                                    ? 3'h2 : 3'h1;
                    prev_cmd_reg <= cmd_reg;
                    state_reg    <= ST_OPC;
                end
                default:
                    state_reg <= ST_OPC;
            endcase
            // Second result word: next frame carries low word
            if (state_reg == ST_OPC && frame_done && res_left_reg == 3'h2)
            begin
                res_left_reg <= 3'h1;
                pend_reg     <= {1'b0, result_reg[15:0]};
            end
        end
    end

    function automatic logic is_wr_cmd(input logic [7:0] o);
        return o == OP_WRITE || o == OP_FILL;
    endfunction

endmodule : dsc_engine
`default_nettype wire

/* logic/dsc_pkg.sv */
// Shared constants and types for the debug serial command engine
`default_nettype none
package dsc_pkg;
    localparam int unsigned FRAME_BITS    = 17;
    localparam int unsigned WORD_BITS     = 16;
    // Response words
    localparam logic [15:0] RSP_OK        = 16'hFFFF;
    localparam logic [15:0] RSP_NOT_READY = 16'h0000;
    localparam logic [15:0] RSP_BUS_ERR   = 16'h0001;
    localparam logic [15:0] RSP_ILLEGAL   = 16'hFFFF;
    // Opcode high bytes; no-op is a whole 16-bit word
    localparam logic [7:0]  OP_RREG       = 8'h21;
    localparam logic [7:0]  OP_WREG       = 8'h20;
    localparam logic [7:0]  OP_READ       = 8'h19;
    localparam logic [7:0]  OP_WRITE      = 8'h18;
    localparam logic [7:0]  OP_DUMP       = 8'h1D;
    localparam logic [7:0]  OP_FILL       = 8'h1C;
    localparam logic [15:0] OP_NOP        = 16'h0000;
    // Register commands need this nibble pattern in bits 7..4
    localparam logic [3:0]  REG_NIB       = 4'h8;
    // Field positions
    localparam int unsigned AD_BIT        = 3;
    localparam int unsigned SZ_HI         = 7;
    localparam int unsigned SZ_LO         = 6;
    // Operand sizes
    localparam logic [1:0]  SZ_BYTE       = 2'h0;
    localparam logic [1:0]  SZ_WORD       = 2'h1;
    localparam logic [1:0]  SZ_LONG       = 2'h2;
    // Idle gap after a non-memory transfer, in processor clocks
    localparam int unsigned GAP_CLKS      = 32;
    // Host clock divider half period in system clocks
    localparam int unsigned HALF_DIV      = 4;
    typedef enum logic [2:0]
    {
        DSC_MEM_NONE  = 3'h0,
        DSC_MEM_READ  = 3'h1,
        DSC_MEM_WRITE = 3'h2
    } dsc_mem_t;
endpackage : dsc_pkg
`default_nettype wire

/* logic/dsc_link_if.sv */
// Serial link between development host and debug engine
`default_nettype none
interface dsc_link_if;
    logic sclk;
    logic sdi;
    logic sdo;
    modport dev  (input sclk, input sdi, output sdo);
    modport host (output sclk, output sdi, input sdo);
endinterface : dsc_link_if
`default_nettype wire

/* logic/dsc_host.sv */
// Development host end: serialises 17-bit frames on the debug link
`default_nettype none
module dsc_host
(
    input  wire logic                sys_clk_in,
    input  wire logic                rst_n_in,
    input  wire logic                clk_en_in,
    dsc_link_if.host                 link,
    input  wire logic                word_valid_in,
    input  wire logic [15:0]         word_in,
    output logic                     busy_out,
    output logic                     resp_valid_out,
    output logic [16:0]              resp_out
);
    import dsc_pkg::*;

    typedef enum logic [2:0]
    {
        HS_IDLE = 3'h1,
        HS_LOW  = 3'h2,
        HS_HIGH = 3'h4
    } dsc_hstate_t;

    dsc_hstate_t hstate_reg;
    logic [16:0] shift_reg;
    logic [16:0] rx_reg;
    logic [4:0]  bits_reg;
    logic [3:0]  div_reg;
    logic        sclk_reg;
    logic        sdi_reg;
    logic [1:0]  sdo_sync_reg;

    // Response bit synchroniser
    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            sdo_sync_reg <= 2'h0;
        else if (clk_en_in)
            sdo_sync_reg <= {sdo_sync_reg[0], link.sdo};
    end

    // Divided clock, MSB first, 17 bits
    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            hstate_reg     <= HS_IDLE;
            shift_reg      <= 17'h0;
            rx_reg         <= 17'h0;
            bits_reg       <= 5'h0;
            div_reg        <= 4'h0;
            sclk_reg       <= 1'b0;
            sdi_reg        <= 1'b0;
            busy_out       <= 1'b0;
            resp_valid_out <= 1'b0;
            resp_out       <= 17'h0;
        end
        else if (clk_en_in)
        begin
            resp_valid_out <= 1'b0;
            unique case (hstate_reg)
                HS_IDLE:
                    if (word_valid_in)
                    begin
                        // Control bit sent clear
                        shift_reg  <= {1'b0, word_in};
                        sdi_reg    <= 1'b0;
                        bits_reg   <= 5'h0;
                        div_reg    <= 4'h0;
                        busy_out   <= 1'b1;
                        hstate_reg <= HS_LOW;
                    end
                HS_LOW:
                begin
                    div_reg <= div_reg + 4'h1;
                    if (div_reg == 4'(HALF_DIV - 1))
                    begin
                        div_reg    <= 4'h0;
                        sclk_reg   <= 1'b1;
                        hstate_reg <= HS_HIGH;
                    end
                end
                HS_HIGH:
                begin
                    div_reg <= div_reg + 4'h1;
                    if (div_reg == 4'(HALF_DIV - 1))
                    begin
                        div_reg  <= 4'h0;
                        sclk_reg <= 1'b0;
                        rx_reg   <= {rx_reg[15:0], sdo_sync_reg[1]};
                        shift_reg <= {shift_reg[15:0], 1'b0};
                        sdi_reg  <= shift_reg[15];
                        bits_reg <= bits_reg + 5'h1;
                        if (bits_reg == 5'(FRAME_BITS - 1))
                        begin
                            resp_out       <= {rx_reg[15:0], sdo_sync_reg[1]};
                            resp_valid_out <= 1'b1;
                            busy_out       <= 1'b0;
                            hstate_reg     <= HS_IDLE;
                        end
                        else
                            hstate_reg <= HS_LOW;
                    end
                end
                default:
                    hstate_reg <= HS_IDLE;
            endcase
            if (hstate_reg == HS_IDLE && word_valid_in)
                sdi_reg <= 1'b0;
            else if (hstate_reg == HS_IDLE)
                sdi_reg <= 1'b0;
        end
    end
    assign link.sclk = sclk_reg;
    assign link.sdi  = sdi_reg;

endmodule : dsc_host
`default_nettype wire

/* test/dsc_link_chk.sv */
// Assertions on the serial debug link between host and engine
`default_nettype none
module dsc_link_chk
(
    input  wire logic  sys_clk_in,
    input  wire logic  rst_n_in,
    input  wire logic  sclk,
    input  wire logic  sdi,
    input  wire logic  sdo
);
    logic       sclk_reg;
    logic [4:0] rise_reg;
    logic [3:0] idle_reg;
    // Rising edges per frame and idle length
    always_ff @(posedge sys_clk_in or negedge rst_n_in)
        if (!rst_n_in)
        begin
            sclk_reg <= 1'h0;
            rise_reg <= 5'h0;
            idle_reg <= 4'h0;
        end
        else
        begin
            sclk_reg <= sclk;
            idle_reg <= sclk ? 4'h0 : idle_reg + {3'h0, idle_reg != 4'hF};
            if (sclk && !sclk_reg)
                rise_reg <= rise_reg + 5'h1;
            else if (idle_reg == 4'hA)
                rise_reg <= 5'h0;
        end
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);
    chk_sclk_high: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
        else $error("serial clock high phase wrong");
    chk_sclk_low: assert property ($fell(sclk) && rise_reg != 5'h11 |-> !sclk [*4] ##1 sclk)
        else $error("serial clock low phase wrong");
    chk_frame_len: assert property (idle_reg == 4'h9 && rise_reg != 5'h0 |-> rise_reg == 5'h11)
        else $error("frame bit count wrong");
    chk_rise_bound: assert property (rise_reg <= 5'h11)
        else $error("frame too long");
    chk_ctrl_bit: assert property ($rose(sclk) && rise_reg == 5'h0 |-> !sdi)
        else $error("control bit not clear");
    chk_sdi_hold: assert property (sclk && $past(sclk) |-> $stable(sdi))
        else $error("host data moved while clock high");
    chk_sdo_quiet: assert property ($changed(sdo) |-> idle_reg <= 4'h4)
        else $error("device data moved outside a frame");
    chk_idle_low: assert property ($fell(sclk) && rise_reg == 5'h11 |-> !sclk [*8])
        else $error("serial clock ran after frame");
endmodule // dsc_link_chk
`default_nettype wire

/* test/debug_serial_command_engine_tb.sv */
// Testbench joining the debug host and engine over the serial link
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fails++; \
    $display("MISMATCH %0t got %h exp %h", $time, a, b); end end
module debug_serial_command_engine_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import dsc_pkg::*;
    localparam logic [16:0] NR = {1'h1, RSP_NOT_READY}, OK = {1'h0, RSP_OK};
    localparam logic [16:0] ILL = {1'h1, RSP_ILLEGAL}, BE = {1'h1, RSP_BUS_ERR};
    logic        sys_clk_in = 1'h0, rst_n_in = 1'h0, clk_en_in = 1'h1, cpu_halted_in = 1'h1;
    logic        mem_req_out, mem_we_out, mem_done_in = 1'h0, mem_err_in = 1'h0, reg_we_out;
    logic        word_valid_in = 1'h0, busy_out, resp_valid_out, we_q;
    logic [4:0]  attr_tt_tm_in = 5'h15, mem_attr_out;
    logic [1:0]  mem_size_out;
    logic [3:0]  reg_sel_out, s_q;
    logic [15:0] word_in = 16'h0;
    logic [16:0] resp_out, r;
    logic [31:0] mem_addr_out, mem_wdata_out, reg_wdata_out, a_q, w_q, rg_q;
    logic [31:0] mem_rdata_in = 32'h0, reg_rdata_in = 32'hCAFE1234;
    int          fails = 0, check_count = 0, cnt = 0;
    dsc_link_if dsc_link_if_inst ();
    dsc_engine dsc_engine_inst (.sys_clk_in, .rst_n_in, .clk_en_in, .link(dsc_link_if_inst),
        .cpu_halted_in, .attr_tt_tm_in, .mem_req_out, .mem_we_out, .mem_addr_out, .mem_size_out,
        .mem_wdata_out, .mem_attr_out, .mem_done_in, .mem_err_in, .mem_rdata_in, .reg_we_out,
        .reg_sel_out, .reg_wdata_out, .reg_rdata_in);
    dsc_host dsc_host_inst (.sys_clk_in, .rst_n_in, .clk_en_in, .link(dsc_link_if_inst),
        .word_valid_in, .word_in, .busy_out, .resp_valid_out, .resp_out);
    dsc_link_chk dsc_link_chk_inst (.sys_clk_in, .rst_n_in, .sclk(dsc_link_if_inst.sclk),
        .sdi(dsc_link_if_inst.sdi), .sdo(dsc_link_if_inst.sdo));
    always #50 sys_clk_in = ~sys_clk_in;
    // Slow memory and register capture
    always @(posedge sys_clk_in)
    begin
        mem_done_in <= 1'h0;
        if (reg_we_out) {s_q, rg_q} <= {reg_sel_out, reg_wdata_out};
        if (mem_req_out && !mem_done_in) cnt <= cnt + 1;
        if (cnt == 200)
        begin
            mem_done_in  <= 1'h1;
            mem_rdata_in <= mem_size_out == SZ_BYTE ? {4{8'hA7}} : 32'h12345678;
            {we_q, a_q, w_q} <= {mem_we_out, mem_addr_out, mem_wdata_out};
            cnt          <= 0;
        end
    end
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic xfer(input logic [15:0] w);
        bit got = 1'b0;
        repeat (12) @(posedge sys_clk_in);
        word_valid_in <= 1'h1;
        word_in       <= w;
        @(posedge sys_clk_in);
        word_valid_in <= 1'h0;
        repeat (400)
        begin
            @(posedge sys_clk_in);
            got = resp_valid_out === 1'h1;
            if (got) break;
        end
        r = resp_out;
        if (!got) fails++;
    endtask
    task automatic tx(input logic [15:0] w, input logic [16:0] e);
        xfer(w);
        `CHK(r, e)
    endtask
    task automatic poll(input logic [16:0] e);
        for (int i = 0; i < 8; i++)
        begin
            xfer(OP_NOP);
            if (r !== NR) break;
        end
        `CHK(r, e)
    endtask
    initial
    begin
        #6000000;
        fails++;
        report_and_stop();
    end
    initial
    begin
        repeat (10) @(posedge sys_clk_in);
        rst_n_in <= 1'h1;
        tx(OP_NOP, OK);
        tx(16'h218B, OK);
        repeat (40) @(posedge sys_clk_in);
        tx(OP_NOP, NR);
        tx(16'h0000, 17'h0CAFE);
        tx(OP_NOP, 17'h01234);
        `CHK(reg_sel_out, 4'hB)
        tx(16'h2085, OK);
        tx(16'hDEAD, NR);
        xfer(16'hBEEF);
        repeat (40) @(posedge sys_clk_in);
        tx(OP_NOP, NR);
        tx(16'h3F00, OK);
        tx(16'h1D40, ILL);
        `CHK({s_q, rg_q}, 36'h5DEADBEEF)
        tx(OP_NOP, ILL);
        cpu_halted_in <= 1'h0;
        xfer(16'h2183);
        repeat (40) @(posedge sys_clk_in);
        tx(OP_NOP, NR);
        tx(OP_NOP, BE);
        cpu_halted_in <= 1'h1;
        xfer(OP_NOP);
        $display("register tests done");
        tx(16'h1940, OK);
        tx(16'h1234, NR);
        tx(16'h5679, NR);
        poll(17'h05678);
        `CHK({we_q, a_q, mem_attr_out}, {1'h0, 32'h12345678, 5'h15})
        tx(16'h1D40, OK);
        poll(17'h05678);
        `CHK(a_q, 32'h1234567A)
        tx(16'h1D00, OK);
        poll(17'h000A7);
        `CHK(a_q, 32'h1234567C)
        tx(16'h1980, OK);
        tx(16'h0000, NR);
        tx(16'h0007, NR);
        poll(17'h01234);
        tx(OP_NOP, 17'h05678);
        `CHK(a_q, 32'h00000004)
        $display("read tests done");
        tx(16'h1800, OK);
        xfer(16'h0000);
        xfer(16'h0011);
        xfer(16'h00AB);
        poll(OK);
        `CHK({we_q, a_q, w_q[7:0]}, {1'h1, 32'h11, 8'hAB})
        tx(16'h1C40, OK);
        xfer(16'hBEEF);
        poll(OK);
        `CHK({a_q, w_q[15:0]}, {32'h12, 16'hBEEF})
        mem_err_in <= 1'h1;
        tx(16'h1940, OK);
        tx(16'h0000, NR);
        tx(16'h0002, NR);
        poll(BE);
        mem_err_in <= 1'h0;
        $display("write and error tests done");
        report_and_stop();
    end
endmodule // debug_serial_command_engine_tb
`default_nettype wire
